// ===== design/cmf_map.svh
// cmf_map.svh: register offsets, reset values and flag positions of the
// mailbox request/status flag block.
// assumes a 32-bit classic wishbone slave with byte addresses.
`ifndef CMF_MAP_SVH
`define CMF_MAP_SVH

// ============================================================
// register byte offsets
`define CMF_OFF_TRS   8'h00
`define CMF_OFF_TRR   8'h04
`define CMF_OFF_TA    8'h08
`define CMF_OFF_AA    8'h0C
`define CMF_OFF_RMP   8'h10
`define CMF_OFF_RML   8'h14
`define CMF_OFF_MD    8'h18
`define CMF_OFF_MIM   8'h1C
`define CMF_OFF_OPC   8'h20
`define CMF_OFF_GIF   8'h24

// ============================================================
// reset values
`define CMF_RST_VEC   32'h0000_0000

// ============================================================
// flag bit positions in the global flag register
`define CMF_GIF_MBX   15
`define CMF_GIF_ABT   14

`endif

// ===== design/cmf_pkg.sv
// cmf_pkg: carrier and state types of the mailbox flag block.
// assumes 32 mailboxes and 5-bit transmit priority levels.
package cmf_pkg;

    // ============================================================
    // wishbone request and response
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } cmf_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } cmf_wb_rsp_t;

    // ============================================================
    // events from the message engine
    typedef struct packed {
        logic        tx_busy;
        logic [4:0]  tx_idx;
        logic        tx_ok;
        logic        tx_abort;
        logic        reply;
        logic [4:0]  reply_idx;
        logic        rx_store;
        logic [31:0] rx_match;
    } cmf_eng_evt_t;

    // ============================================================
    // answers to the message engine
    typedef struct packed {
        logic        tx_valid;
        logic [4:0]  tx_idx;
        logic        rx_ok;
        logic [4:0]  rx_idx;
        logic [31:0] tx_cancel;
    } cmf_eng_ans_t;

    // ============================================================
    // whole state of the block
    typedef struct packed {
        logic [31:0]  tx_request_bit;
        logic [31:0]  tx_cancel_bit;
        logic [31:0]  ta;
        logic [31:0]  aa;
        logic [31:0]  rx_pending_bit;
        logic [31:0]  rx_lost_bit;
        logic [31:0]  md;
        logic [31:0]  mim;
        logic [31:0]  overwrite_protect_bit;
        logic         gmif;
        logic         abort_irq_flag;
        cmf_wb_rsp_t  rsp;
        cmf_eng_ans_t ans;
    } cmf_state_t;

endpackage

// ===== design/cmf_flags.sv
// cmf_flags: per-mailbox transmit request, cancel, acknowledge and receive
// pending flags with a classic wishbone register slave.
// assumes the message engine runs on mclk_in and gives one-cycle event pulses.
`timescale 1ns/1ps
`include "cmf_map.svh"

module cmf_flags
    import cmf_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire cmf_wb_req_t      wb_req_in,
    output cmf_wb_rsp_t           wb_rsp_out,
    input  wire cmf_eng_evt_t     eng_evt_in,
    input  wire logic [31:0]      rtr_bits_in,
    input  wire logic [31:0][4:0] tx_priority_level_in,
    output cmf_eng_ans_t          eng_ans_out,
    output logic                  global_mailbox_irq_flag_out,
    output logic                  abort_irq_flag_out
);

    // ============================================================
    // helpers
    function automatic logic [31:0] onehot(input logic [4:0] idx);
        return 32'h0000_0001 << idx;
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // highest level wins, ties go to the higher mailbox number
    function automatic logic [5:0] pick_mb(input logic [31:0]      v,
                                           input logic [31:0][4:0] lvl);
        logic [4:0] best;
        logic [5:0] r;
        best = 5'h00;
        r    = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i] && (!r[5] || lvl[i] >= best)) begin
                best = lvl[i];
                r    = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    // ============================================================
    // state
    cmf_state_t  s;
    cmf_state_t  next_s;
    logic [31:0] busy_v;
    logic [31:0] ok_v;
    logic [31:0] ab_v;
    logic [31:0] cancel_v;
    logic [31:0] trs_set;
    logic [31:0] trs_clr;
    logic [31:0] trr_w1s;
    logic [31:0] trr_clr;
    logic [31:0] w1c_aa;
    logic [31:0] w1c_ta;
    logic [31:0] w1c_rmp;
    logic [31:0] rmp_set;
    logic [31:0] rx_free;
    logic [31:0] elig;
    logic        acc;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] wm;
    logic [5:0]  rx_pick;
    logic [5:0]  tx_pick;

    // ============================================================
    // next state
    always_comb begin
        next_s   = s;
        acc      = wb_req_in.cyc & wb_req_in.stb;
        wr       = acc & wb_req_in.we & s.rsp.ack;
        wm       = byte_mask(wb_req_in.sel);
        wd       = wb_req_in.dat & wm;
        busy_v   = eng_evt_in.tx_busy ? onehot(eng_evt_in.tx_idx) : 32'h0000_0000;
        ok_v     = eng_evt_in.tx_ok ? onehot(eng_evt_in.tx_idx) : 32'h0000_0000;
        ab_v     = eng_evt_in.tx_abort ? onehot(eng_evt_in.tx_idx) : 32'h0000_0000;
        cancel_v = s.tx_cancel_bit & s.tx_request_bit & ~busy_v & ~ok_v & ~ab_v;
        trs_set  = (wr && wb_req_in.adr == `CMF_OFF_TRS) ? wd : 32'h0000_0000;
        if (eng_evt_in.reply) begin
            trs_set = trs_set | onehot(eng_evt_in.reply_idx);
        end
        trs_clr  = ok_v | ab_v | cancel_v;
        w1c_ta   = (wr && wb_req_in.adr == `CMF_OFF_TA) ? wd : 32'h0000_0000;
        w1c_rmp  = (wr && wb_req_in.adr == `CMF_OFF_RMP) ? wd : 32'h0000_0000;
        w1c_aa   = (wr && wb_req_in.adr == `CMF_OFF_AA) ? wd : 32'h0000_0000;
        trr_w1s  = (wr && wb_req_in.adr == `CMF_OFF_TRR) ? wd : 32'h0000_0000;
        trr_clr  = ok_v | ab_v | (s.tx_cancel_bit & ~s.tx_request_bit & ~busy_v) | cancel_v;

        // request and cancel: set wins over clear
        next_s.tx_request_bit = (s.tx_request_bit & ~trs_clr) | trs_set;
        next_s.tx_cancel_bit = (s.tx_cancel_bit & ~trr_clr) | trr_w1s;

        // acknowledge flags; a sent remote request leaves done untouched
        next_s.ta = (s.ta & ~w1c_ta) | (ok_v & ~s.md);
        next_s.aa = (s.aa & ~w1c_aa)
                  | ab_v | cancel_v;

        // receive: protected full mailboxes are passed over
        rx_free = eng_evt_in.rx_match & ~(s.rx_pending_bit & s.overwrite_protect_bit);
        rx_pick = pick_mb(rx_free, '0);
        rmp_set = (eng_evt_in.rx_store && rx_pick[5]) ? onehot(rx_pick[4:0])
                                                      : 32'h0000_0000;
        next_s.rx_pending_bit = (s.rx_pending_bit & ~w1c_rmp) | rmp_set;
        next_s.rx_lost_bit = (s.rx_lost_bit & ~w1c_rmp) | (rmp_set & s.rx_pending_bit);

        // configuration
        if (wr && wb_req_in.adr == `CMF_OFF_MD) begin
            next_s.md = (s.md & ~wm) | wd;
        end
        if (wr && wb_req_in.adr == `CMF_OFF_MIM) begin
            next_s.mim = (s.mim & ~wm) | wd;
        end
        if (wr && wb_req_in.adr == `CMF_OFF_OPC) begin
            next_s.overwrite_protect_bit = (s.overwrite_protect_bit & ~wm) | wd;
        end

        // global flags follow the stored bits, so clearing a bit drops them
        next_s.gmif = |((next_s.ta | next_s.rx_pending_bit) & next_s.mim);
        next_s.abort_irq_flag = |next_s.aa;

        // transmit choice for the engine
        elig    = next_s.tx_request_bit & (~next_s.md | rtr_bits_in);
        tx_pick = pick_mb(elig, tx_priority_level_in);
        next_s.ans.tx_valid  = tx_pick[5];
        next_s.ans.tx_idx    = tx_pick[4:0];
        next_s.ans.rx_ok     = eng_evt_in.rx_store & rx_pick[5];
        next_s.ans.rx_idx    = rx_pick[4:0];
        next_s.ans.tx_cancel = next_s.tx_cancel_bit;

        // bus: ack one cycle after the request, released the cycle after
        next_s.rsp.ack = acc & ~s.rsp.ack;
        if (acc && !s.rsp.ack) begin
            unique case (wb_req_in.adr)
                `CMF_OFF_TRS: next_s.rsp.dat = s.tx_request_bit;
                `CMF_OFF_TRR: next_s.rsp.dat = s.tx_cancel_bit;
                `CMF_OFF_TA:  next_s.rsp.dat = s.ta;
                `CMF_OFF_AA:  next_s.rsp.dat = s.aa;
                `CMF_OFF_RMP: next_s.rsp.dat = s.rx_pending_bit;
                `CMF_OFF_RML: next_s.rsp.dat = s.rx_lost_bit;
                `CMF_OFF_MD:  next_s.rsp.dat = s.md;
                `CMF_OFF_MIM: next_s.rsp.dat = s.mim;
                `CMF_OFF_OPC: next_s.rsp.dat = s.overwrite_protect_bit;
                `CMF_OFF_GIF: begin
                    next_s.rsp.dat = `CMF_RST_VEC;
                    next_s.rsp.dat[`CMF_GIF_MBX] = s.gmif;
                    next_s.rsp.dat[`CMF_GIF_ABT] = s.abort_irq_flag;
                end
                default:      next_s.rsp.dat = `CMF_RST_VEC;
            endcase
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp_out                  = s.rsp;
    assign eng_ans_out                 = s.ans;
    assign global_mailbox_irq_flag_out = s.gmif;
    assign abort_irq_flag_out          = s.abort_irq_flag;

    // ============================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    trs_set_wins_a: assert property (
        (trs_set & trs_clr) != 32'h0 |=> ((s.tx_request_bit & $past(trs_set & trs_clr))
                                          == $past(trs_set & trs_clr)))
        else $error("request set lost against clear");

    tx_done_a: assert property (
        eng_evt_in.tx_ok && !s.md[eng_evt_in.tx_idx] && !s.tx_cancel_bit[eng_evt_in.tx_idx]
        |=> s.ta[$past(eng_evt_in.tx_idx)] && !(s.tx_request_bit[$past(eng_evt_in.tx_idx)]
            && !$past(trs_set[eng_evt_in.tx_idx])))
        else $error("success did not ack and clear request");

    remote_no_ta_a: assert property (
        eng_evt_in.tx_ok && s.md[eng_evt_in.tx_idx] && !w1c_ta[eng_evt_in.tx_idx]
        |=> s.ta[$past(eng_evt_in.tx_idx)] == $past(s.ta[eng_evt_in.tx_idx]))
        else $error("remote request changed done flag");

    cancel_idle_a: assert property (
        cancel_v != 32'h0 && (trs_set & cancel_v) == 32'h0
        |=> (s.tx_request_bit & $past(cancel_v)) == 32'h0 ##0 (s.aa & $past(cancel_v)) == $past(cancel_v))
        else $error("idle cancel did not abort");

    cancel_busy_a: assert property (
        eng_evt_in.tx_busy && s.tx_cancel_bit[eng_evt_in.tx_idx] && !eng_evt_in.tx_ok
        && !eng_evt_in.tx_abort |=> s.tx_cancel_bit[$past(eng_evt_in.tx_idx)])
        else $error("busy cancel cleared early");

    done_w1c_a: assert property (
        w1c_ta != 32'h0 && (ok_v & w1c_ta) == 32'h0
        |=> (s.ta & $past(w1c_ta)) == 32'h0)
        else $error("done flag not cleared by one");

    rx_lost_a: assert property (
        rmp_set != 32'h0 && (s.rx_pending_bit & rmp_set) != 32'h0 |=> (s.rx_lost_bit & $past(rmp_set)) != 32'h0)
        else $error("overwrite did not set lost bit");

    rmp_clear_a: assert property (
        w1c_rmp != 32'h0 && (rmp_set & w1c_rmp) == 32'h0
        |=> ((s.rx_pending_bit | s.rx_lost_bit) & $past(w1c_rmp)) == 32'h0)
        else $error("pending clear missed pending or lost");

    protect_skip_a: assert property (
        eng_evt_in.rx_store |=> ($past(s.rx_pending_bit & s.overwrite_protect_bit) & $past(rmp_set)) == 32'h0)
        else $error("protected mailbox overwritten");

    mbx_flag_a: assert property (
        ##1 s.gmif == |(($past(next_s.ta) | $past(next_s.rx_pending_bit)) & $past(next_s.mim)))
        else $error("global mailbox flag wrong");

    ack_pulse_a: assert property (
        s.rsp.ack |=> !s.rsp.ack)
        else $error("ack held two cycles");

    // ============================================================
    // checks: set beats clear
    cancel_set_wins_a: assert property (
        (trr_w1s & trr_clr) != 32'h0
        |=> (s.tx_cancel_bit & $past(trr_w1s)) == $past(trr_w1s))
        else $error("cancel set lost against clear");

    done_set_wins_a: assert property (
        (ok_v & ~s.md & w1c_ta) != 32'h0
        |=> (s.ta & $past(ok_v)) == $past(ok_v & ~s.md))
        else $error("done set lost against clear");

    abort_set_wins_a: assert property (
        (ab_v & w1c_aa) != 32'h0
        |=> (s.aa & $past(ab_v)) == $past(ab_v))
        else $error("abort set lost against clear");

    pend_set_wins_a: assert property (
        (rmp_set & w1c_rmp) != 32'h0
        |=> (s.rx_pending_bit & $past(rmp_set)) == $past(rmp_set))
        else $error("pending set lost against clear");

    // ============================================================
    // checks: request and cancel bits
    req_w1s_a: assert property (
        wr && wb_req_in.adr == `CMF_OFF_TRS && trs_clr == 32'h0
        |=> s.tx_request_bit == ($past(s.tx_request_bit) | $past(trs_set)))
        else $error("request write not set-only");

    cancel_rise_a: assert property (
        1'b1
        |=> (s.tx_cancel_bit & ~$past(s.tx_cancel_bit) & ~$past(trr_w1s)) == 32'h0)
        else $error("cancel bit set without a write");

    reply_set_a: assert property (
        eng_evt_in.reply
        |=> s.tx_request_bit[$past(eng_evt_in.reply_idx)])
        else $error("reply did not set request");

    abort_clr_req_a: assert property (
        eng_evt_in.tx_abort && !trs_set[eng_evt_in.tx_idx]
        |=> !s.tx_request_bit[$past(eng_evt_in.tx_idx)])
        else $error("abort left request set");

    remote_clr_a: assert property (
        eng_evt_in.tx_ok && s.md[eng_evt_in.tx_idx] && !trs_set[eng_evt_in.tx_idx]
        |=> !s.tx_request_bit[$past(eng_evt_in.tx_idx)])
        else $error("remote request not cleared");

    busy_keep_req_a: assert property (
        eng_evt_in.tx_busy && !eng_evt_in.tx_ok && !eng_evt_in.tx_abort
        && s.tx_request_bit[eng_evt_in.tx_idx] |=> s.tx_request_bit[$past(eng_evt_in.tx_idx)])
        else $error("busy request dropped early");

    tx_pick_a: assert property (
        s.ans.tx_valid
        |-> s.tx_request_bit[s.ans.tx_idx])
        else $error("offered mailbox has no request");

    // ============================================================
    // checks: acknowledge flags and global flags
    abort_flag_a: assert property (
        ab_v != 32'h0
        |=> (s.aa & $past(ab_v)) == $past(ab_v) && s.abort_irq_flag)
        else $error("abort did not raise flags");

    abort_clear_a: assert property (
        w1c_aa != 32'h0 && ((ab_v | cancel_v) & w1c_aa) == 32'h0
        |=> (s.aa & $past(w1c_aa)) == 32'h0)
        else $error("abort flag not cleared by one");

    done_irq_a: assert property (
        (ok_v & ~s.md & s.mim) != 32'h0 && !(wr && wb_req_in.adr == `CMF_OFF_MIM)
        |=> s.gmif)
        else $error("unmasked done raised no flag");

    pend_irq_a: assert property (
        (rmp_set & s.mim) != 32'h0 && !(wr && wb_req_in.adr == `CMF_OFF_MIM)
        |=> s.gmif)
        else $error("unmasked pending raised no flag");

    // ============================================================
    // checks: receive side and bus
    rx_high_a: assert property (
        eng_evt_in.rx_store && rx_free != 32'h0
        |=> s.ans.rx_ok && ($past(rx_free) >> s.ans.rx_idx) == 32'h0000_0001)
        else $error("receive did not take highest mailbox");

    pend_rise_a: assert property (
        1'b1
        |=> (s.rx_pending_bit & ~$past(s.rx_pending_bit) & ~$past(rmp_set)) == 32'h0)
        else $error("pending set without a message");

    pend_fall_a: assert property (
        1'b1
        |=> ($past(s.rx_pending_bit) & ~s.rx_pending_bit & ~$past(w1c_rmp)) == 32'h0)
        else $error("pending cleared without a write");

    lost_with_pend_a: assert property (
        (s.rx_lost_bit & ~s.rx_pending_bit) == 32'h0)
        else $error("lost bit without pending bit");

    ack_answer_a: assert property (
        acc && !s.rsp.ack
        |=> s.rsp.ack)
        else $error("request not acknowledged");

    ack_idle_a: assert property (
        !acc
        |=> !s.rsp.ack)
        else $error("ack without request");

endmodule

// ===== tb/cmf_eng_model.sv
// cmf_eng_model: stand-in for the message engine beside the flag block.
// assumes the bench calls its tasks right after a rising edge of mclk_in.
`timescale 1ns/1ps
module cmf_eng_model
    import cmf_pkg::*;
(
    input  wire logic         mclk_in,
    input  wire cmf_eng_ans_t ans_in,
    output cmf_eng_evt_t      evt_out
);
    initial evt_out = '0;

    // ============================================================
    // take the mailbox the block offers and hold it busy
    task automatic start_tx(output logic [4:0] i);
        i = ans_in.tx_idx;
        evt_out.tx_busy <= 1'b1;
        evt_out.tx_idx  <= i;
        @(posedge mclk_in);
    endtask

    // ============================================================
    // one-cycle event: 0 success, 1 abort, 2 reply, 3 store
    task automatic pulse(input int k, input logic [4:0] i, input logic [31:0] m);
        evt_out.tx_ok     <= (k == 0);
        evt_out.tx_abort  <= (k == 1);
        evt_out.reply     <= (k == 2);
        evt_out.rx_store  <= (k == 3);
        evt_out.reply_idx <= i;
        evt_out.rx_match  <= m;
        if (k < 2)
            evt_out.tx_idx <= i;
        @(posedge mclk_in);
        evt_out.tx_ok     <= 1'b0;
        evt_out.tx_abort  <= 1'b0;
        evt_out.reply     <= 1'b0;
        evt_out.rx_store  <= 1'b0;
        // idle qualifiers do not keep their last value
        evt_out.reply_idx <= ~i;
        evt_out.rx_match  <= ~m;
        if (k < 2) begin
            evt_out.tx_busy <= 1'b0;
            evt_out.tx_idx  <= ~i;
        end
        @(posedge mclk_in);
    endtask
endmodule

// ===== tb/cmf_flags_test.sv
// cmf_flags_test: self-checking bench for the mailbox flag block.
// assumes cmf_eng_model as the engine and the offsets of cmf_map.svh.
`timescale 1ns/1ps
`include "cmf_map.svh"
module cmf_flags_test
    import cmf_pkg::*;
;
    logic             mclk_in = 1'b0;
    logic             nrst_in;
    cmf_wb_req_t      req;
    cmf_wb_rsp_t      rsp;
    cmf_eng_evt_t     evt;
    cmf_eng_ans_t     ans;
    logic [31:0]      rtr;
    logic [31:0][4:0] lvl;
    logic             gmif;
    logic             abort_irq_flag;
    logic [4:0]       idx;
    int               num_errors = 0;
    int               num_checks = 0;

    cmf_flags DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_req_in(req),
        .wb_rsp_out(rsp), .eng_evt_in(evt), .rtr_bits_in(rtr),
        .tx_priority_level_in(lvl), .eng_ans_out(ans),
        .global_mailbox_irq_flag_out(gmif), .abort_irq_flag_out(abort_irq_flag));
    cmf_eng_model eng (.mclk_in(mclk_in), .ans_in(ans), .evt_out(evt));

    always #5 mclk_in = ~mclk_in;

    // ============================================================
    // compare, bus cycle and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        @(posedge mclk_in);
        while (rsp.ack !== 1'b1 && n < 20) begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 20)
            num_errors++;
        q = rsp.dat;
        req <= '0;
        @(posedge mclk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
            rc(8'(i * 4), 32'h0000_0000);
        rc(8'h3C, 32'h0000_0000);
        $display("reset test done");
    endtask

    task automatic t_req();
        wr(`CMF_OFF_TRS, 32'h0000_0009);
        wr(`CMF_OFF_TRS, 32'h0000_0000);
        rc(`CMF_OFF_TRS, 32'h0000_0009);
        chk(ans.tx_valid, 1'b1);
        chk(ans.tx_idx, 5'h03);
        lvl[0] <= 5'h01;
        repeat (2) @(posedge mclk_in);
        chk(ans.tx_idx, 5'h00);
        lvl[0] <= 5'h00;
        $display("request test done");
    endtask

    task automatic t_ok();
        wr(`CMF_OFF_MIM, 32'h0000_0008);
        eng.start_tx(idx);
        chk(idx, 5'h03);
        eng.pulse(0, 5'h03, '0);
        chk(gmif, 1'b1);
        rc(`CMF_OFF_TRS, 32'h0000_0001);
        rc(`CMF_OFF_TA, 32'h0000_0008);
        wr(`CMF_OFF_TA, 32'h0000_0008);
        chk(gmif, 1'b0);
        rc(`CMF_OFF_TA, 32'h0000_0000);
        eng.start_tx(idx);
        fork
            wr(`CMF_OFF_TRS, 32'h0000_0001);
            begin
                @(posedge mclk_in);
                eng.pulse(0, 5'h00, '0);
            end
        join
        rc(`CMF_OFF_TRS, 32'h0000_0001);
        rc(`CMF_OFF_TA, 32'h0000_0001);
        wr(`CMF_OFF_TA, 32'h0000_0001);
        $display("success test done");
    endtask

    task automatic t_cancel();
        wr(`CMF_OFF_TRR, 32'h0000_0001);
        rc(`CMF_OFF_TRS, 32'h0000_0000);
        rc(`CMF_OFF_AA, 32'h0000_0001);
        rc(`CMF_OFF_TRR, 32'h0000_0000);
        chk(abort_irq_flag, 1'b1);
        wr(`CMF_OFF_AA, 32'h0000_0000);
        rc(`CMF_OFF_AA, 32'h0000_0001);
        wr(`CMF_OFF_AA, 32'h0000_0001);
        rc(`CMF_OFF_AA, 32'h0000_0000);
        chk(abort_irq_flag, 1'b0);
        $display("idle cancel test done");
    endtask

    task automatic t_busy();
        wr(`CMF_OFF_TRS, 32'h0000_0020);
        eng.start_tx(idx);
        wr(`CMF_OFF_TRR, 32'h0000_0020);
        chk(ans.tx_cancel, 32'h0000_0020);
        rc(`CMF_OFF_TRS, 32'h0000_0020);
        rc(`CMF_OFF_TRR, 32'h0000_0020);
        eng.pulse(1, 5'h05, '0);
        rc(`CMF_OFF_TRR, 32'h0000_0000);
        rc(`CMF_OFF_TRS, 32'h0000_0000);
        rc(`CMF_OFF_AA, 32'h0000_0020);
        wr(`CMF_OFF_AA, 32'h0000_0020);
        $display("busy cancel test done");
    endtask

    task automatic t_remote();
        wr(`CMF_OFF_MD, 32'h0000_0004);
        wr(`CMF_OFF_TRS, 32'h0000_0004);
        chk(ans.tx_valid, 1'b0);
        rtr <= 32'h0000_0004;
        repeat (2) @(posedge mclk_in);
        chk(ans.tx_idx, 5'h02);
        eng.start_tx(idx);
        eng.pulse(0, 5'h02, '0);
        rc(`CMF_OFF_TRS, 32'h0000_0000);
        rc(`CMF_OFF_TA, 32'h0000_0000);
        eng.pulse(2, 5'h07, '0);
        rc(`CMF_OFF_TRS, 32'h0000_0080);
        $display("remote test done");
    endtask

    task automatic t_rx();
        wr(`CMF_OFF_MIM, 32'h0000_0010);
        eng.pulse(3, 5'h00, 32'h0000_0012);
        chk(ans.rx_ok, 1'b1);
        chk(ans.rx_idx, 5'h04);
        chk(gmif, 1'b1);
        eng.pulse(3, 5'h00, 32'h0000_0012);
        rc(`CMF_OFF_RMP, 32'h0000_0010);
        rc(`CMF_OFF_RML, 32'h0000_0010);
        wr(`CMF_OFF_RMP, 32'h0000_0010);
        rc(`CMF_OFF_RML, 32'h0000_0000);
        chk(gmif, 1'b0);
        wr(`CMF_OFF_OPC, 32'h0000_0010);
        eng.pulse(3, 5'h00, 32'h0000_0012);
        eng.pulse(3, 5'h00, 32'h0000_0012);
        chk(ans.rx_idx, 5'h01);
        rc(`CMF_OFF_RMP, 32'h0000_0012);
        rc(`CMF_OFF_RML, 32'h0000_0000);
        $display("receive test done");
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        req = '0;
        rtr = '0;
        lvl = '0;
        nrst_in = 1'b0;
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_req();
        t_ok();
        t_cancel();
        t_busy();
        t_remote();
        t_rx();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge mclk_in);
        num_errors++;
        report_and_stop();
    end
endmodule
